// ---- rtl/nv_cfg.svh ----
// Function
// - No array write happens unless write_permit is one.
// - Write-go with write_permit starts a write; hardware clears it when done.
// - No array read happens unless read_permit is one.
// - Read-go with read_permit starts a read; hardware clears it when done.
// - Data register holds the fetched byte until the next read or write.
// - Write duration is paced by the internal asynchronous write timer.
// - All four control bits reset to zero at power-on.
// - Bank pointer resets to zero, hiding the control register in bank 1.
// - Cycle end sets the completion flag and the multi-function flag.
// - Vector request needs global, completion and multi-function enables, stack not full.
// - Servicing clears only the multi-function flag; software clears the completion flag.
// - Array is 64 bytes with six address bits; upper address bits read zero.
// - Control register sits at 40H of bank 1, reached only indirectly.
`ifndef NV_CFG_SVH
`define NV_CFG_SVH

// ----------------------------------------
// Special function register addresses
// ----------------------------------------
`define SFR_NV_ADDRESS 8'h10
`define SFR_NV_DATA 8'h11
`define SFR_BANK_POINTER 8'h12
`define SFR_INDIRECT_POINTER_ONE 8'h13
`define SFR_INDIRECT_ACCESS 8'h14
`define SFR_IRQ_CTRL 8'h15

// ----------------------------------------
// Control register location and fields
// ----------------------------------------
`define NV_CTRL_BANK 8'h01
`define NV_CTRL_LOC 8'h40
`define NV_CTRL_WRITE_PERMIT_BIT 3
`define NV_CTRL_WRITE_GO_BIT 2
`define NV_CTRL_READ_PERMIT_BIT 1
`define NV_CTRL_READ_GO_BIT 0

// ----------------------------------------
// Interrupt control fields
// ----------------------------------------
`define IRQ_NV_ENABLE_BIT 0
`define IRQ_MF_ENABLE_BIT 1
`define IRQ_NV_FLAG_BIT 2
`define IRQ_MF_FLAG_BIT 3
`define IRQ_GLOBAL_ENABLE_BIT 4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define BANK_POINTER_RESET 8'h00
`define INDIRECT_POINTER_RESET 8'h00
`define NV_READ_CYCLES 4'h2
`define NV_WRITE_TICKS 4'h4

`endif

// ---- rtl/nv_pkg.sv ----
package nv_pkg;
	typedef enum logic [1:0] {st_idle, st_reading, st_writing} nv_state_t;
	typedef logic [5:0] nv_addr_t;
	typedef logic [7:0] nv_byte_t;
endpackage

// ---- rtl/nv_array_if.sv ----
interface nv_array_if;
	logic req_rd;
	logic req_wr;
	nv_pkg::nv_addr_t addr;
	nv_pkg::nv_byte_t wdata;
	nv_pkg::nv_byte_t rdata;
	logic done;
	modport ctrl (output req_rd, output req_wr, output addr, output wdata, input rdata, input done);
	modport mem (input req_rd, input req_wr, input addr, input wdata, output rdata, output done);
endinterface

// ---- rtl/nv_array.sv ----
`include "nv_cfg.svh"

module nv_array (
	input wire logic clk,
	input wire logic rst,
	input wire logic write_timer_tick,
	nv_array_if.mem port
);
	nv_pkg::nv_state_t state_reg;
	nv_pkg::nv_state_t state_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic done_reg;
	logic done_next;
	nv_pkg::nv_addr_t addr_reg;
	nv_pkg::nv_byte_t wdata_reg;
	nv_pkg::nv_byte_t rdata_reg;
	nv_pkg::nv_byte_t cell_reg [0:63];

	wire take_req = (state_reg == nv_pkg::st_idle) && (port.req_rd || port.req_wr);
	wire finish_wr = (state_reg == nv_pkg::st_writing) && done_next;
	wire finish_rd = (state_reg == nv_pkg::st_reading) && done_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		case (state_reg)
			nv_pkg::st_idle: begin
				cnt_next = 4'h0;
				if (port.req_rd) begin
					state_next = nv_pkg::st_reading;
				end else if (port.req_wr) begin
					state_next = nv_pkg::st_writing;
				end
			end
			nv_pkg::st_reading: begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == `NV_READ_CYCLES - 4'h1) begin
					state_next = nv_pkg::st_idle;
					done_next = 1'b1;
				end
			end
			nv_pkg::st_writing: begin
				// Write timer ticks pace the write
				if (write_timer_tick) begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == `NV_WRITE_TICKS - 4'h1) begin
						state_next = nv_pkg::st_idle;
						done_next = 1'b1;
					end
				end
			end
			default: begin
				state_next = nv_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= nv_pkg::st_idle;
			cnt_reg <= 4'h0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	// Request operands captured at start
	always_ff @(posedge clk) begin
		if (take_req) begin
			addr_reg <= port.addr;
			wdata_reg <= port.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (finish_wr) begin
			cell_reg[addr_reg] <= wdata_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (finish_rd) begin
			rdata_reg <= cell_reg[addr_reg];
		end
	end

	assign port.done = done_reg;
	assign port.rdata = rdata_reg;
endmodule

// ---- rtl/data_eeprom_access_ctrl.sv ----
`include "nv_cfg.svh"

module data_eeprom_access_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic write_timer_tick,
	input wire logic stack_full,
	input wire logic irq_ack,
	output logic irq_vector_req
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic write_permit_reg;
	logic write_go_reg;
	logic read_permit_reg;
	logic read_go_reg;
	nv_pkg::nv_addr_t nv_address_reg;
	nv_pkg::nv_byte_t nv_data_reg;
	logic [7:0] bank_pointer_reg;
	logic [7:0] indirect_pointer_one_reg;
	logic nv_irq_enable_reg;
	logic mf_irq_enable_reg;
	logic nv_irq_flag_reg;
	logic mf_irq_flag_reg;
	logic global_irq_enable_reg;
	logic req_rd_reg;
	logic req_wr_reg;
	logic [7:0] sfr_rdata_reg;
	logic irq_vector_req_reg;

	nv_array_if arr ();

	function automatic logic [7:0] ctrl_image(input logic wp, input logic wg,
		input logic rp, input logic rg);
		logic [7:0] img;
		img = 8'h00;
		img[`NV_CTRL_WRITE_PERMIT_BIT] = wp;
		img[`NV_CTRL_WRITE_GO_BIT] = wg;
		img[`NV_CTRL_READ_PERMIT_BIT] = rp;
		img[`NV_CTRL_READ_GO_BIT] = rg;
		return img;
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire ctrl_sel = (bank_pointer_reg == `NV_CTRL_BANK)
		&& (indirect_pointer_one_reg == `NV_CTRL_LOC);
	wire hit_ind = sfr_addr == `SFR_INDIRECT_ACCESS;
	wire wr_ctrl = sfr_wr && hit_ind && ctrl_sel;
	wire wr_addr = sfr_wr && (sfr_addr == `SFR_NV_ADDRESS);
	wire wr_data = sfr_wr && (sfr_addr == `SFR_NV_DATA);
	wire wr_bank = sfr_wr && (sfr_addr == `SFR_BANK_POINTER);
	wire wr_ptr = sfr_wr && (sfr_addr == `SFR_INDIRECT_POINTER_ONE);
	wire wr_irq = sfr_wr && (sfr_addr == `SFR_IRQ_CTRL);
	wire ops_idle = !write_go_reg && !read_go_reg;
	wire start_wr = wr_ctrl && sfr_wdata[`NV_CTRL_WRITE_GO_BIT]
		&& write_permit_reg && ops_idle;
	wire start_rd = wr_ctrl && sfr_wdata[`NV_CTRL_READ_GO_BIT] && read_permit_reg
		&& ops_idle && !sfr_wdata[`NV_CTRL_WRITE_GO_BIT];
	wire nv_flag_clr = wr_irq && !sfr_wdata[`IRQ_NV_FLAG_BIT];
	wire mf_flag_clr = (wr_irq && !sfr_wdata[`IRQ_MF_FLAG_BIT]) || irq_ack;
	wire irq_cond = global_irq_enable_reg && nv_irq_enable_reg && mf_irq_enable_reg
		&& mf_irq_flag_reg && !stack_full;
	wire [7:0] irq_image = {3'h0, global_irq_enable_reg, mf_irq_flag_reg,
		nv_irq_flag_reg, mf_irq_enable_reg, nv_irq_enable_reg};
	wire [7:0] ctrl_now = ctrl_image(write_permit_reg, write_go_reg,
		read_permit_reg, read_go_reg);
	wire [7:0] rd_mux =
		(sfr_addr == `SFR_NV_ADDRESS) ? {2'h0, nv_address_reg} :
		(sfr_addr == `SFR_NV_DATA) ? nv_data_reg :
		(sfr_addr == `SFR_BANK_POINTER) ? bank_pointer_reg :
		(sfr_addr == `SFR_INDIRECT_POINTER_ONE) ? indirect_pointer_one_reg :
		(sfr_addr == `SFR_INDIRECT_ACCESS && ctrl_sel) ? ctrl_now :
		(sfr_addr == `SFR_IRQ_CTRL) ? irq_image : 8'h00;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			write_permit_reg <= 1'b0;
			read_permit_reg <= 1'b0;
			write_go_reg <= 1'b0;
			read_go_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				write_permit_reg <= sfr_wdata[`NV_CTRL_WRITE_PERMIT_BIT];
				read_permit_reg <= sfr_wdata[`NV_CTRL_READ_PERMIT_BIT];
			end
			if (start_wr) begin
				write_go_reg <= 1'b1;
			end else if (arr.done) begin
				write_go_reg <= 1'b0;
			end
			if (start_rd) begin
				read_go_reg <= 1'b1;
			end else if (arr.done) begin
				read_go_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			req_wr_reg <= 1'b0;
			req_rd_reg <= 1'b0;
		end else begin
			req_wr_reg <= start_wr;
			req_rd_reg <= start_rd;
		end
	end

	// ----------------------------------------
	// Direct registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			nv_address_reg <= 6'h00;
			nv_data_reg <= 8'h00;
			bank_pointer_reg <= `BANK_POINTER_RESET;
			indirect_pointer_one_reg <= `INDIRECT_POINTER_RESET;
		end else begin
			if (wr_addr) begin
				nv_address_reg <= sfr_wdata[5:0];
			end
			if (arr.done && read_go_reg) begin
				nv_data_reg <= arr.rdata;
			end else if (wr_data) begin
				nv_data_reg <= sfr_wdata;
			end
			if (wr_bank) begin
				bank_pointer_reg <= sfr_wdata;
			end
			if (wr_ptr) begin
				indirect_pointer_one_reg <= sfr_wdata;
			end
		end
	end

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			nv_irq_enable_reg <= 1'b0;
			mf_irq_enable_reg <= 1'b0;
			global_irq_enable_reg <= 1'b0;
			nv_irq_flag_reg <= 1'b0;
			mf_irq_flag_reg <= 1'b0;
			irq_vector_req_reg <= 1'b0;
		end else begin
			if (wr_irq) begin
				nv_irq_enable_reg <= sfr_wdata[`IRQ_NV_ENABLE_BIT];
				mf_irq_enable_reg <= sfr_wdata[`IRQ_MF_ENABLE_BIT];
				global_irq_enable_reg <= sfr_wdata[`IRQ_GLOBAL_ENABLE_BIT];
			end
			// Set wins over clear
			nv_irq_flag_reg <= arr.done || (nv_irq_flag_reg && !nv_flag_clr);
			mf_irq_flag_reg <= arr.done || (mf_irq_flag_reg && !mf_flag_clr);
			irq_vector_req_reg <= irq_cond;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sfr_rdata_reg <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata_reg <= rd_mux;
		end
	end

	assign arr.req_rd = req_rd_reg;
	assign arr.req_wr = req_wr_reg;
	assign arr.addr = nv_address_reg;
	assign arr.wdata = nv_data_reg;
	assign sfr_rdata = sfr_rdata_reg;
	assign irq_vector_req = irq_vector_req_reg;

	nv_array u_array (
		.clk(clk),
		.rst(rst),
		.write_timer_tick(write_timer_tick),
		.port(arr)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_wr_needs_permit;
		@(posedge clk) disable iff (rst) $rose(write_go_reg) |-> $past(write_permit_reg);
	endproperty
	a_wr_needs_permit: assert property (p_wr_needs_permit)
		else $error("write started without write permit");

	property p_wr_start;
		@(posedge clk) disable iff (rst)
		(wr_ctrl && sfr_wdata[`NV_CTRL_WRITE_GO_BIT] && write_permit_reg && ops_idle)
		|=> write_go_reg && req_wr_reg ##1 !req_wr_reg;
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("write go did not start a write");

	property p_rd_needs_permit;
		@(posedge clk) disable iff (rst) req_rd_reg |-> $past(read_permit_reg);
	endproperty
	a_rd_needs_permit: assert property (p_rd_needs_permit)
		else $error("read issued without read permit");

	property p_rd_latency;
		@(posedge clk) disable iff (rst) $rose(read_go_reg) |-> read_go_reg[*4] ##1 !read_go_reg;
	endproperty
	a_rd_latency: assert property (p_rd_latency)
		else $error("read cycle length wrong");

	property p_rd_data;
		@(posedge clk) disable iff (rst) (arr.done && read_go_reg) |=> nv_data_reg == $past(arr.rdata);
	endproperty
	a_rd_data: assert property (p_rd_data)
		else $error("data register not loaded by read");

	property p_done_flags;
		@(posedge clk) disable iff (rst)
		arr.done |=> nv_irq_flag_reg && mf_irq_flag_reg && !write_go_reg && !read_go_reg;
	endproperty
	a_done_flags: assert property (p_done_flags)
		else $error("completion did not set flags or clear go bits");

	property p_vector;
		@(posedge clk) disable iff (rst) irq_vector_req |-> $past(irq_cond);
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector request without all conditions");

	property p_ack_keeps_nv_flag;
		@(posedge clk) disable iff (rst)
		(irq_ack && nv_irq_flag_reg && !wr_irq) |=> nv_irq_flag_reg && (!mf_irq_flag_reg || $past(arr.done));
	endproperty
	a_ack_keeps_nv_flag: assert property (p_ack_keeps_nv_flag)
		else $error("service acknowledge handled flags wrongly");

	property p_reset_state;
		@(posedge clk) rst |=> ctrl_now == 8'h00 && bank_pointer_reg == 8'h00;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("control or bank pointer not cleared by reset");

	property p_addr_upper;
		@(posedge clk) disable iff (rst) (sfr_rd && sfr_addr == `SFR_NV_ADDRESS)
		|=> sfr_rdata == {2'h0, $past(nv_address_reg)};
	endproperty
	a_addr_upper: assert property (p_addr_upper)
		else $error("address upper bits not zero");

	c_read: cover property (@(posedge clk) disable iff (rst) arr.done && read_go_reg);
	c_write: cover property (@(posedge clk) disable iff (rst) arr.done && write_go_reg);
	c_vector: cover property (@(posedge clk) disable iff (rst) irq_vector_req);
endmodule

// ---- verification/tb_top.sv ----
`include "nv_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] IA = `SFR_INDIRECT_ACCESS;
	localparam logic [7:0] IRQ = `SFR_IRQ_CTRL;

	logic clk;
	logic rst;
	logic [7:0] sfr_addr;
	logic sfr_wr;
	logic sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic write_timer_tick;
	logic stack_full;
	logic irq_ack;
	logic irq_vector_req;
	logic [7:0] rv;
	int n_errors;
	int n_compared;
	int mem_model [64];
	int data_model;
	int a;
	int d;
	int wq [$];
	int en_tab [4] = '{8'h03, 8'h11, 8'h12, 8'h13};

	data_eeprom_access_ctrl dut (
		.clk(clk),
		.rst(rst),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata),
		.write_timer_tick(write_timer_tick),
		.stack_full(stack_full),
		.irq_ack(irq_ack),
		.irq_vector_req(irq_vector_req)
	);

	always #2.5 clk = ~clk;

	// ----------------------------------------
	// Write timer, ticking at random
	// ----------------------------------------
	always @(posedge clk) begin
		write_timer_tick <= ($urandom_range(1) == 1);
	end

	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check1(input string name, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [7:0] ad, input logic [7:0] dt);
		sfr_addr <= ad;
		sfr_wdata <= dt;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_rd(input logic [7:0] ad, output logic [7:0] dt);
		sfr_addr <= ad;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		dt = sfr_rdata;
	endtask

	task automatic wait_idle(input logic [7:0] mask);
		logic [7:0] v;
		int i;
		for (i = 0; i < 40; i++) begin
			reg_rd(IA, v);
			if ((v & mask) == 8'h00) break;
		end
		if (i == 40) begin
			n_errors++;
			$display("ERROR go bit expected 00 seen %h", v & mask);
		end
	endtask

	task automatic nv_write(input int ad, input int dt);
		reg_wr(`SFR_NV_ADDRESS, ad[7:0]);
		reg_wr(`SFR_NV_DATA, dt[7:0]);
		reg_wr(IA, 8'h08);
		reg_wr(IA, 8'h0c);
		wait_idle(8'h04);
		mem_model[ad & 63] = dt;
		data_model = dt;
	endtask

	task automatic nv_read(input int ad);
		reg_wr(IA, 8'h02);
		reg_wr(`SFR_NV_ADDRESS, ad[7:0]);
		reg_wr(IA, 8'h03);
		wait_idle(8'h01);
		data_model = mem_model[ad & 63];
	endtask

	task automatic final_report();
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		final_report();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		stack_full = 1'b0;
		irq_ack = 1'b0;
		void'($urandom(32'h2db4));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		reg_rd(IA, rv);
		check8("ctrl in bank 0", 8'h00, rv);
		reg_rd(`SFR_BANK_POINTER, rv);
		check8("bank pointer", 8'h00, rv);
		reg_rd(8'h3a, rv);
		check8("unmapped", 8'h00, rv);
		reg_wr(`SFR_INDIRECT_POINTER_ONE, `NV_CTRL_LOC);
		reg_wr(IA, 8'h0a);
		reg_wr(`SFR_BANK_POINTER, `NV_CTRL_BANK);
		reg_rd(IA, rv);
		check8("ctrl after reset", 8'h00, rv);
		reg_wr(IA, 8'h04);
		reg_rd(IA, rv);
		check8("write go no permit", 8'h00, rv);
		reg_wr(IA, 8'h01);
		reg_rd(IA, rv);
		check8("read go no permit", 8'h00, rv);
		// Writes, boundary addresses first
		for (int i = 0; i < 10; i++) begin
			a = (i == 0) ? 0 : (i == 1) ? 63 : $urandom_range(255);
			d = $urandom_range(255);
			nv_write(a, d);
			wq.push_back(a);
			reg_rd(IA, rv);
			check8("ctrl after write", 8'h08, rv);
			reg_rd(`SFR_NV_DATA, rv);
			check8("data after write", data_model[7:0], rv);
			reg_rd(`SFR_NV_ADDRESS, rv);
			check8("address reg", a[7:0] & 8'h3f, rv);
			reg_rd(IRQ, rv);
			check8("flags after write", 8'h0c, rv);
			reg_wr(IRQ, 8'h00);
		end
		foreach (wq[i]) begin
			nv_read(wq[i]);
			reg_rd(`SFR_NV_DATA, rv);
			check8("read data", data_model[7:0], rv);
			reg_rd(IRQ, rv);
			check8("flags after read", 8'h0c, rv);
			reg_wr(IRQ, 8'h00);
		end
		// Blocked read keeps the data register
		reg_wr(`SFR_NV_DATA, 8'h5a);
		reg_wr(IA, 8'h00);
		reg_wr(IA, 8'h01);
		repeat (8) @(posedge clk);
		reg_rd(IA, rv);
		check8("blocked read ctrl", 8'h00, rv);
		reg_rd(`SFR_NV_DATA, rv);
		check8("blocked read data", 8'h5a, rv);
		// Blocked write leaves the array alone
		reg_wr(`SFR_NV_ADDRESS, wq[0][7:0]);
		reg_wr(`SFR_NV_DATA, ~mem_model[wq[0] & 63][7:0]);
		reg_wr(IA, 8'h04);
		repeat (20) @(posedge clk);
		nv_read(wq[0]);
		reg_rd(`SFR_NV_DATA, rv);
		check8("blocked write", data_model[7:0], rv);
		// Vector request needs every enable
		foreach (en_tab[i]) begin
			reg_wr(IRQ, en_tab[i][7:0]);
			nv_read(wq[1]);
			check1("vector req", en_tab[i] == 8'h13, irq_vector_req);
		end
		reg_wr(IRQ, 8'h13);
		stack_full <= 1'b1;
		nv_read(wq[2]);
		check1("vector req stack full", 1'b0, irq_vector_req);
		stack_full <= 1'b0;
		repeat (2) @(posedge clk);
		check1("vector req stack free", 1'b1, irq_vector_req);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		repeat (2) @(posedge clk);
		check1("vector req after ack", 1'b0, irq_vector_req);
		reg_rd(IRQ, rv);
		check8("flags after ack", 8'h17, rv);
		final_report();
	end
endmodule
